/* twbea_core.sv */
/*
 * Two-wire serial master with bus-error detection, recovery and
 * multi-master arbitration, plus Avalon-MM register slave and interrupt.
 * Assumes open-drain bus lines resolved outside; enables are active low.
 */
// What this block does
// - Status shows 0xF8 whenever the transfer-done flag is clear.
// - START or STOP inside a frame, except in a byte's first clock-high, reports bus error code 0x00.
// - A bus error sets the transfer-done flag.
// - Recovery goes not-addressed slave, clears stop-request and done flag, other bits kept.
// - Recovery releases both lines and sends no STOP.
// - After repeated START the master keeps the bus.
// - Identical traffic from several masters raises no arbitration event.
// - Driving one while line reads zero loses arbitration and stops driving.
// - Loser in direction or data goes not-addressed slave or retries START.
// - Address bits arbitrate with the same wired-zero rule.
// - Loser in address checks own address, reports slave receive (0x68) only, never transmit.
// - Unaddressed address loser goes not-addressed slave or retries START.
`timescale 1ns/100ps
`include "twbea_map.svh"

module twbea_core #(
    parameter int          HALF_CYC = `TWBEA_HALF_CYC,
    parameter logic [6:0]  OWN_ADDR = 7'h2A
) (
    input  wire logic        CORE_CLK_I,
    input  wire logic        RST_I,
    input  wire logic [4:0]  AVS_ADDRESS_I,
    input  wire logic        AVS_READ_I,
    input  wire logic        AVS_WRITE_I,
    input  wire logic [31:0] AVS_WRITEDATA_I,
    output logic      [31:0] AVS_READDATA_O,
    output logic             AVS_WAITREQUEST_O,
    input  wire logic        SCL_I,
    input  wire logic        SDA_I,
    output logic             SCL_O,
    output logic             SCL_OE_N_O,
    output logic             SDA_O,
    output logic             SDA_OE_N_O,
    output logic             IRQ_O
);

    // ****************************************************************
    // Line synchronisers and condition detect
    // ****************************************************************
    twbea_pkg::twbea_lines_t meta_reg;
    twbea_pkg::twbea_lines_t sync_reg;
    twbea_pkg::twbea_lines_t prev_reg;

    // Two stages before anything looks at the pins
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            meta_reg <= 2'b11;
            sync_reg <= 2'b11;
            prev_reg <= 2'b11;
        end else begin
            meta_reg <= '{scl: SCL_I, sda: SDA_I};
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    wire start_seen = sync_reg.scl && prev_reg.scl && prev_reg.sda && !sync_reg.sda;
    wire stop_seen  = sync_reg.scl && prev_reg.scl && !prev_reg.sda && sync_reg.sda;
    wire scl_rise   = sync_reg.scl && !prev_reg.scl;

    // ****************************************************************
    // Registers
    // ****************************************************************
    twbea_pkg::twbea_state_t state_reg;
    logic [5:0]  ctrl_reg;
    logic [7:0]  status_reg;
    logic [7:0]  data_reg;
    logic [7:0]  shift_reg;
    logic [3:0]  bit_cnt_reg;
    logic        addr_phase_reg;
    logic        in_frame_reg;
    logic        master_reg;
    logic        slave_sel_reg;
    logic [2:0]  irq_st_reg;
    logic [2:0]  irq_mask_reg;
    logic [15:0] div_reg;
    logic        phase_reg;
    logic        sda_drv_reg;
    logic        scl_drv_reg;
    logic        rd_valid_reg;

    // Bus decode
    wire wr_ctrl  = AVS_WRITE_I && (AVS_ADDRESS_I == 5'(`TWBEA_CTRL_ADDR));
    wire wr_data  = AVS_WRITE_I && (AVS_ADDRESS_I == 5'(`TWBEA_DATA_ADDR));
    wire wr_irq   = AVS_WRITE_I && (AVS_ADDRESS_I == 5'(`TWBEA_IRQ_ADDR));
    wire wr_mask  = AVS_WRITE_I && (AVS_ADDRESS_I == 5'(`TWBEA_MASK_ADDR));
    wire done     = ctrl_reg[`TWBEA_CTL_DONE];
    wire done_clr = wr_ctrl && AVS_WRITEDATA_I[`TWBEA_CTL_DONE];
    wire recover  = done_clr && AVS_WRITEDATA_I[`TWBEA_CTL_STOP_REQ]
                    && (status_reg == `TWBEA_ST_BUS_ERR);
    wire enabled  = ctrl_reg[`TWBEA_CTL_ENABLE];

    // Bit timing enable; HALF_CYC of 5 or more lets the synced bit count settle
    wire tick = (div_reg == 16'(HALF_CYC - 1));

    // Bus error: a condition is legal only in the first clock-high of a byte,
    // where repeated START and STOP sit; anywhere else in a frame it is not
    wire bus_err = in_frame_reg && (start_seen || stop_seen)
                   && (bit_cnt_reg != 4'h1);

    // Master drives one, line reads zero on a sampling edge
    // The eighth rise lands in the ack state, so only the ack clock is exempt
    wire arb_lost = master_reg && scl_rise && sda_drv_reg && !sync_reg.sda
                    && (state_reg == twbea_pkg::TWBEA_BITS
                        || state_reg == twbea_pkg::TWBEA_ACK)
                    && (bit_cnt_reg != 4'h8);

    // Event strobes for done, bus error, arbitration
    logic set_done;
    logic [7:0] new_status;

    // ****************************************************************
    // Divider
    // ****************************************************************
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I || tick || state_reg == twbea_pkg::TWBEA_IDLE) begin
            div_reg <= 16'h0000;
        end else begin
            div_reg <= div_reg + 16'h0001;
        end
    end

    // ****************************************************************
    // Frame tracker, also for traffic of other masters
    // ****************************************************************
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I || stop_seen || recover) begin
            in_frame_reg   <= 1'b0;
            bit_cnt_reg    <= 4'h0;
            addr_phase_reg <= 1'b0;
            slave_sel_reg  <= 1'b0;
            shift_reg      <= 8'h00;
        end else if (start_seen) begin
            in_frame_reg   <= 1'b1;
            bit_cnt_reg    <= 4'h0;
            addr_phase_reg <= 1'b1;
        end else if (in_frame_reg && scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sync_reg.sda};
            bit_cnt_reg <= (bit_cnt_reg == 4'h8) ? 4'h0 : bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == 4'h8) begin
                addr_phase_reg <= 1'b0;
                if (addr_phase_reg && shift_reg[7:1] == OWN_ADDR) begin
                    slave_sel_reg <= 1'b1;
                end
            end
        end
    end

    // ****************************************************************
    // Master byte engine
    // ****************************************************************
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            state_reg   <= twbea_pkg::TWBEA_IDLE;
            master_reg  <= 1'b0;
            sda_drv_reg <= 1'b1;
            scl_drv_reg <= 1'b1;
            phase_reg   <= 1'b0;
            set_done    <= 1'b0;
            new_status  <= `TWBEA_ST_NO_INFO;
        end else begin
            set_done <= 1'b0;
            if (bus_err || recover) begin
                // Lines let go at once, no STOP driven
                state_reg   <= twbea_pkg::TWBEA_IDLE;
                master_reg  <= 1'b0;
                sda_drv_reg <= 1'b1;
                scl_drv_reg <= 1'b1;
                set_done    <= bus_err;
                new_status  <= `TWBEA_ST_BUS_ERR;
            end else if (arb_lost) begin
                // Stop driving; software picks slave or a fresh START
                state_reg   <= twbea_pkg::TWBEA_IDLE;
                master_reg  <= 1'b0;
                sda_drv_reg <= 1'b1;
                scl_drv_reg <= 1'b1;
                set_done    <= 1'b1;
                new_status  <= !addr_phase_reg ? `TWBEA_ST_ARB_LOST :
                               (shift_reg[6:0] != OWN_ADDR) ? `TWBEA_ST_ARB_LOST :
                               `TWBEA_ST_ARB_SLA_W;
            end else begin
                unique case (state_reg)
                    twbea_pkg::TWBEA_IDLE: begin
                        // Start only on a free bus, or restart while owning it
                        if (enabled && !done && ctrl_reg[`TWBEA_CTL_START_REQ]
                            && (!in_frame_reg || master_reg)) begin
                            state_reg  <= twbea_pkg::TWBEA_START;
                            master_reg <= 1'b1;
                            phase_reg  <= 1'b0;
                        end else if (enabled && !done && master_reg
                                     && ctrl_reg[`TWBEA_CTL_STOP_REQ]) begin
                            state_reg <= twbea_pkg::TWBEA_STOP;
                            phase_reg <= 1'b0;
                        end
                    end
                    twbea_pkg::TWBEA_START: if (tick) begin
                        phase_reg <= !phase_reg;
                        if (!phase_reg) begin
                            sda_drv_reg <= 1'b1;
                            scl_drv_reg <= 1'b1;
                        end else begin
                            sda_drv_reg <= 1'b0;
                            state_reg   <= twbea_pkg::TWBEA_BITS;
                        end
                    end
                    twbea_pkg::TWBEA_BITS, twbea_pkg::TWBEA_ACK: if (tick) begin
                        phase_reg   <= !phase_reg;
                        scl_drv_reg <= phase_reg;
                        if (!phase_reg) begin
                            sda_drv_reg <= (state_reg == twbea_pkg::TWBEA_ACK)
                                           ? 1'b1 : data_reg[7 - bit_cnt_reg[2:0]];
                        end else if (state_reg == twbea_pkg::TWBEA_ACK) begin
                            // Ninth clock rises now, then the engine parks
                            state_reg <= twbea_pkg::TWBEA_HOLD;
                        end else if (bit_cnt_reg == 4'h7) begin
                            // Eighth clock rises now; next low phase frees the line
                            state_reg <= twbea_pkg::TWBEA_ACK;
                        end
                    end
                    twbea_pkg::TWBEA_HOLD: if (tick) begin
                        // Ack clock stands a half bit, then held low for software
                        scl_drv_reg <= 1'b0;
                        set_done    <= 1'b1;
                        new_status  <= `TWBEA_ST_BYTE_DONE;
                        state_reg   <= twbea_pkg::TWBEA_IDLE;
                    end
                    twbea_pkg::TWBEA_STOP: if (tick) begin
                        phase_reg <= !phase_reg;
                        if (!phase_reg) begin
                            sda_drv_reg <= 1'b0;
                            scl_drv_reg <= 1'b1;
                        end else begin
                            sda_drv_reg <= 1'b1;
                            master_reg  <= 1'b0;
                            state_reg   <= twbea_pkg::TWBEA_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // Control, status, data registers
    // ****************************************************************
    // Done flag: a hardware set beats a clear in the same cycle
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            ctrl_reg   <= 6'h00;
            status_reg <= `TWBEA_ST_NO_INFO;
            data_reg   <= 8'h00;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= {AVS_WRITEDATA_I[5:4], 1'b0, AVS_WRITEDATA_I[2:0]};
            end
            if (recover) begin
                // Stop-request and done drop, other bits as held
                ctrl_reg                      <= ctrl_reg;
                ctrl_reg[`TWBEA_CTL_STOP_REQ] <= 1'b0;
                ctrl_reg[`TWBEA_CTL_DONE]     <= 1'b0;
            end else if (done_clr) begin
                ctrl_reg[`TWBEA_CTL_DONE] <= 1'b0;
            end else if (wr_ctrl) begin
                ctrl_reg[`TWBEA_CTL_DONE] <= ctrl_reg[`TWBEA_CTL_DONE];
            end
            if (set_done) begin
                ctrl_reg[`TWBEA_CTL_DONE] <= 1'b1;
                status_reg                <= new_status;
            end else if (done_clr) begin
                status_reg <= `TWBEA_ST_NO_INFO;
            end
            if (wr_data) begin
                data_reg <= AVS_WRITEDATA_I[7:0];
            end
        end
    end

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    wire [2:0] irq_ev = {set_done && (new_status == `TWBEA_ST_ARB_LOST
                                      || new_status == `TWBEA_ST_ARB_SLA_W),
                         set_done && (new_status == `TWBEA_ST_BUS_ERR),
                         set_done};

    // Write-one-to-clear, new event wins
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            irq_st_reg   <= 3'h0;
            irq_mask_reg <= 3'h0;
        end else begin
            irq_st_reg <= (irq_st_reg & ~(wr_irq ? AVS_WRITEDATA_I[2:0] : 3'h0)) | irq_ev;
            if (wr_mask) begin
                irq_mask_reg <= AVS_WRITEDATA_I[2:0];
            end
        end
    end

    // ****************************************************************
    // Read path: one wait state then data
    // ****************************************************************
    wire [7:0] shown_status = done ? status_reg : `TWBEA_ST_NO_INFO;
    logic [31:0] rd_mux;
    always_comb begin
        unique case (AVS_ADDRESS_I)
            5'(`TWBEA_CTRL_ADDR): rd_mux = {26'h0, ctrl_reg};
            5'(`TWBEA_STAT_ADDR): rd_mux = {24'h0, shown_status};
            5'(`TWBEA_DATA_ADDR): rd_mux = {24'h0, slave_sel_reg ? shift_reg : data_reg};
            5'(`TWBEA_IRQ_ADDR):  rd_mux = {29'h0, irq_st_reg};
            5'(`TWBEA_MASK_ADDR): rd_mux = {29'h0, irq_mask_reg};
            default:              rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            rd_valid_reg   <= 1'b0;
            AVS_READDATA_O <= 32'h0;
        end else begin
            rd_valid_reg   <= AVS_READ_I && !rd_valid_reg;
            AVS_READDATA_O <= rd_mux;
        end
    end

    assign AVS_WAITREQUEST_O = AVS_READ_I && !rd_valid_reg;
    assign IRQ_O             = |(irq_st_reg & irq_mask_reg);
    assign SCL_O             = 1'b0;
    assign SDA_O             = 1'b0;
    assign SCL_OE_N_O        = scl_drv_reg;
    assign SDA_OE_N_O        = sda_drv_reg;

endmodule

/* twbea_map.svh */
/*
 * Register offsets, field positions, status codes and timing counts for the
 * two-wire bus error and arbitration block.
 * Assumes inclusion by bare name from the design module and the bench.
 */
`ifndef TWBEA_MAP_SVH
`define TWBEA_MAP_SVH

// ****************************************************************
// Register byte addresses (word aligned)
// ****************************************************************
`define TWBEA_CTRL_ADDR      5'h00
`define TWBEA_STAT_ADDR      5'h04
`define TWBEA_DATA_ADDR      5'h08
`define TWBEA_IRQ_ADDR       5'h0C
`define TWBEA_MASK_ADDR      5'h10

// ****************************************************************
// Control register fields
// ****************************************************************
`define TWBEA_CTL_ACK_EN     0
`define TWBEA_CTL_STOP_REQ   1
`define TWBEA_CTL_START_REQ  2
`define TWBEA_CTL_DONE       3
`define TWBEA_CTL_ENABLE     4
`define TWBEA_CTL_RESTART    5

// ****************************************************************
// Status codes and interrupt bits
// ****************************************************************
`define TWBEA_ST_NO_INFO     8'hF8
`define TWBEA_ST_BUS_ERR     8'h00
`define TWBEA_ST_ARB_LOST    8'h38
`define TWBEA_ST_ARB_SLA_W   8'h68
`define TWBEA_ST_ARB_SLA_R   8'hB0
`define TWBEA_ST_BYTE_DONE   8'h28
`define TWBEA_IRQ_DONE       0
`define TWBEA_IRQ_BUS_ERR    1
`define TWBEA_IRQ_ARB        2

// ****************************************************************
// Timing
// ****************************************************************
`define TWBEA_CLK_MHZ        100
`define TWBEA_BIT_NS         10000
`define TWBEA_HALF_CYC       ((`TWBEA_BIT_NS * `TWBEA_CLK_MHZ) / 2000)

`endif

/* twbea_pkg.sv */
/*
 * Types shared by the two-wire bus error and arbitration block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package twbea_pkg;

    // Byte engine states, one-hot
    typedef enum logic [5:0] {
        TWBEA_IDLE  = 6'h01,
        TWBEA_START = 6'h02,
        TWBEA_BITS  = 6'h04,
        TWBEA_ACK   = 6'h08,
        TWBEA_HOLD  = 6'h10,
        TWBEA_STOP  = 6'h20
    } twbea_state_t;

    // Sampled bus lines
    typedef struct packed {
        logic scl;
        logic sda;
    } twbea_lines_t;

    // Bus line drive pair, enable low drives
    typedef struct packed {
        logic scl_oe_n;
        logic sda_oe_n;
    } twbea_drive_t;

endpackage

/* twbea_core_sva.sv */
/* Checker for twbea_core: register port timing, line release, interrupt level.
   Assumes it is bound to twbea_core and sees only that module's ports. */
`timescale 1ns/100ps
module twbea_core_sva (
    input wire logic        CORE_CLK_I,
    input wire logic        RST_I,
    input wire logic [4:0]  AVS_ADDRESS_I,
    input wire logic        AVS_READ_I,
    input wire logic        AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [31:0] AVS_READDATA_O,
    input wire logic        AVS_WAITREQUEST_O,
    input wire logic        SCL_O,
    input wire logic        SCL_OE_N_O,
    input wire logic        SDA_O,
    input wire logic        SDA_OE_N_O,
    input wire logic        IRQ_O
);
    // ********************************
    // Helper logic and properties
    // ********************************
    logic [2:0] mask_reg;
    wire        rd_ok = AVS_READ_I && !AVS_WAITREQUEST_O;
    wire        mapped = AVS_ADDRESS_I inside {5'h00, 5'h04, 5'h08, 5'h0C, 5'h10};
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);
    // Shadow of the mask; reset low so the irq check never over-claims
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) mask_reg <= 3'h0;
        else if (AVS_WRITE_I && AVS_ADDRESS_I == 5'h10) mask_reg <= AVS_WRITEDATA_I[2:0];
    end
    property p_rd_wait;
        $rose(AVS_READ_I) |-> AVS_WAITREQUEST_O;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read answered at once");
    property p_rd_ans;
        AVS_READ_I && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read wait too long");
    property p_wr_go;
        AVS_WRITE_I |-> !AVS_WAITREQUEST_O;
    endproperty
    a_wr_go: assert property (p_wr_go) else $error("write stalled");
    property p_od;
        SCL_O == 1'b0 && SDA_O == 1'b0;
    endproperty
    a_od: assert property (p_od) else $error("open drain level not low");
    property p_rst;
        disable iff (1'b0) RST_I |=> SCL_OE_N_O && SDA_OE_N_O && !IRQ_O && AVS_READDATA_O == 32'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_unmap;
        rd_ok && !mapped |-> AVS_READDATA_O == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_narrow;
        rd_ok |-> AVS_READDATA_O[31:8] == 24'h0;
    endproperty
    a_narrow: assert property (p_narrow) else $error("upper read bits set");
    property p_code;
        rd_ok && AVS_ADDRESS_I == 5'h04 |-> AVS_READDATA_O[2:0] == 3'h0;
    endproperty
    a_code: assert property (p_code) else $error("status code low bits set");
    property p_err_rel;
        rd_ok && AVS_ADDRESS_I == 5'h04 && AVS_READDATA_O == 32'h0 |-> SCL_OE_N_O && SDA_OE_N_O;
    endproperty
    a_err_rel: assert property (p_err_rel) else $error("line held in bus error");
    property p_irq;
        rd_ok && AVS_ADDRESS_I == 5'h0C && |(AVS_READDATA_O[2:0] & mask_reg) |-> IRQ_O;
    endproperty
    a_irq: assert property (p_irq) else $error("irq low with unmasked event");
endmodule
bind twbea_core twbea_core_sva u_sva (
    .CORE_CLK_I       (CORE_CLK_I),
    .RST_I            (RST_I),
    .AVS_ADDRESS_I    (AVS_ADDRESS_I),
    .AVS_READ_I       (AVS_READ_I),
    .AVS_WRITE_I      (AVS_WRITE_I),
    .AVS_WRITEDATA_I  (AVS_WRITEDATA_I),
    .AVS_READDATA_O   (AVS_READDATA_O),
    .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
    .SCL_O            (SCL_O),
    .SCL_OE_N_O       (SCL_OE_N_O),
    .SDA_O            (SDA_O),
    .SDA_OE_N_O       (SDA_OE_N_O),
    .IRQ_O            (IRQ_O)
);

/* twbea_bus_peer.sv */
/* Far-side bus party: START, STOP, single bits and a data-line grab.
   Assumes the bench builds pull-up wired-AND lines; enable low drives. */
`timescale 1ns/100ps
module twbea_bus_peer (
    input  wire twbea_pkg::twbea_lines_t lines_i,
    output twbea_pkg::twbea_drive_t      drv_o
);
    // ********************************
    // Line tasks, 125 ns link bit
    // ********************************
    initial drv_o = 2'b11;
    // Clock stays high between frames
    task automatic start_cond();
        drv_o.sda_oe_n = 1'b0;
        #62.5 drv_o.scl_oe_n = 1'b0;
        #62.5;
    endtask
    // Data moves only while the clock is low
    task automatic put_bit(input logic b);
        drv_o.sda_oe_n = b;
        #62.5 drv_o.scl_oe_n = 1'b1;
        #62.5 drv_o.scl_oe_n = 1'b0;
    endtask
    // Stop mid-frame is the illegal case
    task automatic stop_cond();
        drv_o.sda_oe_n = 1'b0;
        #62.5 drv_o.scl_oe_n = 1'b1;
        #62.5 drv_o.sda_oe_n = 1'b1;
        #62.5;
    endtask
    // Wired zero beats any one the other master sends
    task automatic grab();
        @(negedge lines_i.scl);
        drv_o.sda_oe_n = 1'b0;
    endtask
    task automatic free();
        drv_o.sda_oe_n = 1'b1;
    endtask
endmodule

/* twbea_core_tb_top.sv */
/* Bench for twbea_core: reset, bus error, recovery, arbitration, interrupt.
   Assumes the core, its checker and the peer model are compiled first. */
`timescale 1ns/100ps
`include "twbea_map.svh"
module twbea_core_tb_top;
    localparam int LIMIT = 40000; // Far above the few hundred cycles used
    logic                    clk;
    logic                    rst;
    logic [4:0]              addr;
    logic                    rd;
    logic                    wr;
    logic [31:0]             wdata;
    logic [31:0]             rdata;
    logic [31:0]             v;
    logic                    waitreq;
    logic                    irq;
    twbea_pkg::twbea_drive_t dut_drv;
    twbea_pkg::twbea_drive_t peer_drv;
    twbea_pkg::twbea_lines_t lines;
    int                      error_cnt = 0;
    int                      checks_done = 0;
    int                      cyc = 0;
    // ********************************
    // Wiring, clock, hang guard
    // ********************************
    assign lines = dut_drv & peer_drv; // Pull-ups: high unless someone drives
    twbea_core #(.HALF_CYC(5)) dut (
        .CORE_CLK_I       (clk),
        .RST_I            (rst),
        .AVS_ADDRESS_I    (addr),
        .AVS_READ_I       (rd),
        .AVS_WRITE_I      (wr),
        .AVS_WRITEDATA_I  (wdata),
        .AVS_READDATA_O   (rdata),
        .AVS_WAITREQUEST_O(waitreq),
        .SCL_I            (lines.scl),
        .SDA_I            (lines.sda),
        .SCL_O            (),
        .SCL_OE_N_O       (dut_drv.scl_oe_n),
        .SDA_O            (),
        .SDA_OE_N_O       (dut_drv.sda_oe_n),
        .IRQ_O            (irq)
    );
    twbea_bus_peer peer (.lines_i(lines), .drv_o(peer_drv));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            error_cnt = error_cnt + 1;
            complete_run();
        end
    end
    // ********************************
    // Bus cycles and compares
    // ********************************
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Request held until waitrequest is seen low at an edge
    task automatic av_wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        while (waitreq !== 1'b0) @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic av_rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        while (waitreq !== 1'b0) @(posedge clk);
        d = rdata;
        rd <= 1'b0;
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] d;
        av_rd(a, d);
        chk(d, exp);
    endtask
    // Reads only while no-info shows; no control action meanwhile
    task automatic poll_stat(input logic [31:0] exp);
        int n = 0;
        v = {24'h0, `TWBEA_ST_NO_INFO};
        while (v === {24'h0, `TWBEA_ST_NO_INFO} && n < 500) begin
            av_rd(5'h04, v);
            n++;
        end
        chk(v, exp);
    endtask
    // ********************************
    // Scenarios
    // ********************************
    task automatic t_reset();
        av_wr(5'h14, 32'h1F);
        rd_chk(5'h04, {24'h0, `TWBEA_ST_NO_INFO});
        rd_chk(5'h00, 32'h0);
        rd_chk(5'h0C, 32'h0);
        rd_chk(5'h14, 32'h0);
        chk({30'h0, dut_drv}, 32'h3);
    endtask
    // Stop after three address bits is out of place
    task automatic t_bus_err();
        av_wr(5'h10, 32'h7);
        av_wr(5'h00, 32'h11);
        peer.start_cond();
        repeat (3) peer.put_bit(1'b0);
        peer.stop_cond();
        poll_stat({24'h0, `TWBEA_ST_BUS_ERR});
        av_rd(5'h00, v);
        chk({31'h0, v[3]}, 32'h1);
        chk({30'h0, dut_drv}, 32'h3);
        chk({31'h0, irq}, 32'h1);
        av_rd(5'h0C, v);
        chk({31'h0, v[1]}, 32'h1);
        av_wr(5'h10, 32'h0);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
    endtask
    task automatic t_recover();
        logic [1:0] seen = 2'b11;
        av_wr(5'h00, 32'h1B);
        rd_chk(5'h00, 32'h11);
        rd_chk(5'h04, {24'h0, `TWBEA_ST_NO_INFO});
        repeat (60) begin
            @(posedge clk);
            seen &= dut_drv;
        end
        chk({30'h0, seen}, 32'h3);
        av_wr(5'h0C, 32'h7);
        rd_chk(5'h0C, 32'h0);
        av_wr(5'h10, 32'h7);
    endtask
    // Byte, repeated START, byte, STOP: the bus stays owned in between
    task automatic t_restart();
        av_wr(5'h08, 32'hA0);
        av_wr(5'h00, 32'h15);
        poll_stat({24'h0, `TWBEA_ST_BYTE_DONE});
        chk({31'h0, dut_drv.scl_oe_n}, 32'h0);
        av_wr(5'h00, 32'h1D);
        poll_stat({24'h0, `TWBEA_ST_BYTE_DONE});
        av_wr(5'h00, 32'h1A);
        repeat (40) @(posedge clk);
        chk({30'h0, dut_drv}, 32'h3);
        rd_chk(5'h04, {24'h0, `TWBEA_ST_NO_INFO});
    endtask
    // Address 0x55 loses on its second bit to a held-low line
    task automatic t_arb();
        av_wr(5'h08, 32'h55);
        fork
            peer.grab();
            av_wr(5'h00, 32'h15);
        join
        poll_stat({24'h0, `TWBEA_ST_ARB_LOST});
        chk({30'h0, dut_drv}, 32'h3);
        av_rd(5'h0C, v);
        chk({31'h0, v[2]}, 32'h1);
        chk({31'h0, irq}, 32'h1);
        peer.free();
    endtask
    initial begin
        rst = 1'b1;
        rd = 1'b0;
        wr = 1'b0;
        addr = 5'h00;
        wdata = 32'h0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_bus_err();
        t_recover();
        t_restart();
        t_arb();
        complete_run();
    end
endmodule
